// [bench/sensor_model.sv]
`timescale 1ns/100ps
module sensor_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Raw reading
  input  wire logic [15:0] set_value,
  // Samples
  output logic             sample_valid,
  output logic      [2:0]  sample_chan,
  output logic      [15:0] sample_value,
  output logic             sample_fault
);
  logic [2:0] cnt;
  // ****************************************
  // Faulted samples, channels in turn
  // ****************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cnt <= 3'h0;
      sample_valid <= 1'b0;
      sample_chan <= 3'h0;
      sample_value <= 16'h0000;
      sample_fault <= 1'b0;
    end
    else
    begin
      sample_valid <= ~sample_valid;
      sample_chan <= cnt;
      sample_value <= sample_valid ? ~set_value : set_value;
      sample_fault <= ~sample_valid;
      if (sample_valid)
      begin
        cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      end
    end
  end
endmodule

// [bench/testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] d;
  logic        s_valid;
  logic        s_fault;
  logic [2:0]  s_chan;
  logic [15:0] s_value;
  logic        o_valid;
  logic [2:0]  o_chan;
  logic [15:0] o_value;
  logic [15:0] pv;
  logic [15:0] sp;
  logic [15:0] pos;
  logic        off;
  logic [4:0]  fault;
  logic [15:0] last_main = 16'h0000;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (o_valid === 1'b1 && o_chan == 3'h0)
      last_main <= o_value;
  end
  sensor_model model (.clk_sys(clk_sys), .reset(reset), .set_value(16'h0123),
    .sample_valid(s_valid), .sample_chan(s_chan), .sample_value(s_value), .sample_fault(s_fault));
  input_preprocessing_chain #(.SCAN_CYCLES(64)) dut (.clk_sys(clk_sys), .reset(reset),
    .sample_valid(s_valid), .sample_chan(s_chan), .sample_value(s_value),
    .sample_fault(s_fault), .cj_internal(16'h0000), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_valid(o_valid), .out_chan(o_chan), .out_value(o_value), .process_value(pv),
    .ext_setpoint(sp), .position_feedback(pos), .outputs_off(off), .sensor_fault(fault));
  // ****************************************
  // Register access and checks
  // ****************************************
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task res(input logic [15:0] fx, input logic [15:0] e);
    wr(8'h30, fx);
    repeat (150) @(posedge clk_sys);
    rd(8'h60);
    chk(d, e);
  endtask
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    wr(8'h08, 16'hFF00);
    wr(8'h10, 16'h0010);
    wr(8'h00, 16'h0081);
    res(16'h0064, 16'hFFAC);
    chk(last_main, 16'hFFAC);
    chk(pv, 16'hFFAC);
    chk(sp, 16'h7FFF);
    chk(pos, 16'h7FFF);
    chk({11'h000, fault}, 16'h001F);
    chk({15'h0000, off}, 16'h0000);
    wr(8'h39, 16'h0001);
    repeat (150) @(posedge clk_sys);
    #1;
    chk(pv, 16'h7FFF);
    wr(8'h39, 16'h0000);
    wr(8'h00, 16'h0083);
    res(16'h0064, 16'h000A);
    res(16'hFFF6, 16'h0000);
    wr(8'h08, 16'h0200);
    wr(8'h10, 16'h0000);
    wr(8'h00, 16'h0099);
    res(16'h0019, 16'h0007);
    wr(8'h00, 16'h008B);
    res(16'h0019, 16'h000A);
    wr(8'h00, 16'h0089);
    rd(8'h3B);
    chk(d & 16'h0100, 16'h0100);
    res(16'h0019, 16'h000A);
    wr(8'h00, 16'h0000);
    res(16'h0019, 16'h7FFF);
    wr(8'h03, 16'h0002);
    rd(8'h3B);
    chk(d & 16'h0100, 16'h0100);
    wr(8'h00, 16'h0300);
    rd(8'h3B);
    chk(d & 16'h0020, 16'h0020);
    wr(8'h3A, 16'h0000);
    rd(8'h3B);
    chk(d & 16'h0020, 16'h0000);
    wr(8'h00, 16'h0040);
    res(16'h0019, 16'h8001);
    wr(8'h40, 16'h0000);
    wr(8'h41, 16'h0000);
    wr(8'h42, 16'h0064);
    wr(8'h43, 16'h00C8);
    wr(8'h00, 16'h0082);
    res(16'h0032, 16'h0064);
    res(16'h0096, 16'h012C);
    end_sim;
  end
endmodule

// [design/input_preprocessing_chain.sv]
`timescale 1ns/100ps
module input_preprocessing_chain #(
  parameter int SCAN_CYCLES   = ppc_pkg::SCAN_CYCLES,
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Sensor samples
  input  wire logic        sample_valid,
  input  wire logic [2:0]  sample_chan,
  input  wire logic [15:0] sample_value,
  input  wire logic        sample_fault,
  input  wire logic [15:0] cj_internal,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Processed values
  output logic             out_valid,
  output logic      [2:0]  out_chan,
  output logic      [15:0] out_value,
  output logic      [15:0] process_value,
  output logic      [15:0] ext_setpoint,
  output logic      [15:0] position_feedback,
  output logic             outputs_off,
  output logic      [4:0]  sensor_fault
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {S_IDLE, S_COND, S_SLOT_A, S_SLOT_B, S_EMIT} phase_e;
  typedef struct packed {
    phase_e                                 phase;
    logic [2:0]                             chan;
    logic [31:0]                            tick;
    logic [15:0]                            work;
    logic [ppc_pkg::CH_N-1:0][15:0]         raw;
    logic [ppc_pkg::CH_N-1:0]               raw_fault;
    logic [ppc_pkg::CH_N-1:0][ppc_pkg::CFG_W-1:0] cfg;
    logic [ppc_pkg::CH_N-1:0][15:0]         lin_gain;
    logic [ppc_pkg::CH_N-1:0][15:0]         lin_off;
    logic [ppc_pkg::CH_N-1:0][15:0]         root_gain;
    logic [ppc_pkg::CH_N-1:0][15:0]         lag_tc;
    logic [ppc_pkg::CH_N-1:0][15:0]         in_tc;
    logic [ppc_pkg::CH_N-1:0][15:0]         fixed_val;
    logic [ppc_pkg::CH_N-1:0][15:0]         filt;
    logic [ppc_pkg::CH_N-1:0][15:0]         lag;
    logic [ppc_pkg::CH_N-1:0][15:0]         result;
    logic [ppc_pkg::CV_N-1:0][ppc_pkg::BP_N-1:0][15:0] bx;
    logic [ppc_pkg::CV_N-1:0][ppc_pkg::BP_N-1:0][15:0] by;
    logic [15:0]                            cj_ref;
    logic [15:0]                            lead_off;
    logic [1:0]                             route;
    logic                                   cal_done;
    logic                                   refused;
    logic [ppc_pkg::CH_N-1:0]               fault_now;
    logic                                   fault_seen;
    logic [7:0]                             settle_cnt;
    logic [7:0]                             off_cnt;
    logic                                   off;
    logic [15:0]                            rdata;
    logic                                   out_valid;
    logic [2:0]                             out_chan;
    logic [15:0]                            out_value;
    logic [15:0]                            pv;
    logic [15:0]                            sp;
    logic [15:0]                            pos;
  } state_s;

  function automatic state_s reset_state();
    state_s s;
    s = '0;
    for (int i = 0; i < ppc_pkg::CH_N; i++)
    begin
      s.lin_gain[i]  = ppc_pkg::GAIN_ONE;
      s.root_gain[i] = ppc_pkg::GAIN_ONE;
      s.lag_tc[i]    = ppc_pkg::TC_MIN;
      s.in_tc[i]     = ppc_pkg::TC_MIN;
    end
    for (int c = 0; c < ppc_pkg::CV_N; c++)
    begin
      for (int p = 0; p < ppc_pkg::BP_N; p++)
      begin
        s.bx[c][p] = ppc_pkg::X_DISABLED;
      end
    end
    return s;
  endfunction

  localparam state_s ST_RESET = reset_state();

  state_s st;
  state_s next_st;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] sat16(input int v);
    if (v > 32767)
      return ppc_pkg::UPSCALE;
    else if (v < -32767)
      return ppc_pkg::DOWNSCALE;
    else
      return v[15:0];
  endfunction

  function automatic logic [15:0] isqrt(input logic [15:0] v);
    logic [15:0] r;
    logic [15:0] t;
    r = '0;
    for (int i = 7; i >= 0; i--)
    begin
      t = r | (16'h0001 << i);
      if (32'(t) * 32'(t) <= 32'(v))
        r = t;
    end
    return r;
  endfunction

  function automatic logic fn_ok(input logic [2:0] ch, input logic [2:0] fn);
    if (fn == ppc_pkg::FN_NONE)
      return 1'b1;
    else if (fn > ppc_pkg::FN_LAG)
      return 1'b0;
    else if ((ch == ppc_pkg::CH_AUX3 || ch == ppc_pkg::CH_AUX4) && !LARGE_VARIANT)
      return 1'b0;
    else if (fn == ppc_pkg::FN_CURVE)
      return ch == ppc_pkg::CH_MAIN || ch == ppc_pkg::CH_AUX4;
    else
      return 1'b1;
  endfunction

  function automatic int coef(input logic [15:0] tc);
    return (1 << ppc_pkg::COEF_FRAC) * ppc_pkg::SAMPLE_UNITS
           / (int'(tc) + ppc_pkg::SAMPLE_UNITS);
  endfunction

  // ****************************************
  // Datapath
  // ****************************************
  logic        cv;
  logic [3:0]  n_used;
  logic [2:0]  seg;
  int          x0;
  int          dx;
  int          y0;
  int          xw;
  logic [15:0] curve_res;
  logic [15:0] lin_res;
  logic [15:0] root_res;
  logic [15:0] lag_res;
  logic [15:0] filt_res;
  logic [15:0] cond_val;
  logic [15:0] subst;
  logic [15:0] fn_res;
  logic [2:0]  cur_fn;
  logic [1:0]  stype;
  logic        fault_cond;
  logic [15:0] rtd_hi;

  always_comb
  begin
    cv = st.chan == ppc_pkg::CH_AUX4;
    xw = int'($signed(st.work));
    n_used = 4'(ppc_pkg::BP_N);
    for (int i = ppc_pkg::BP_N - 1; i >= 0; i--)
    begin
      if (st.bx[cv][i] == ppc_pkg::X_DISABLED)
        n_used = 4'(i);
    end
    seg = 3'h0;
    for (int i = 1; i < ppc_pkg::BP_N - 1; i++)
    begin
      if (4'(i) < n_used - 4'h1 && xw >= int'($signed(st.bx[cv][i])))
        seg = 3'(i);
    end
    x0 = int'($signed(st.bx[cv][seg]));
    y0 = int'($signed(st.by[cv][seg]));
    dx = int'($signed(st.bx[cv][seg + 3'h1])) - x0;
    if (n_used == 4'h0)
      curve_res = st.work;
    else if (n_used == 4'h1 || dx <= 0)
      curve_res = st.by[cv][seg];
    else
      curve_res = sat16(y0 + (int'($signed(st.by[cv][seg + 3'h1])) - y0)
                  * (xw - x0) / dx);
    lin_res = sat16(((int'($signed(st.lin_gain[st.chan])) * xw) >>> ppc_pkg::GAIN_FRAC)
              + int'($signed(st.lin_off[st.chan])));
    if (st.work[15])
      root_res = '0;
    else
      root_res = sat16((int'($signed(st.root_gain[st.chan])) * int'(isqrt(st.work)))
                 >>> ppc_pkg::GAIN_FRAC);
    lag_res = sat16(int'($signed(st.lag[st.chan])) + (((xw - int'($signed(st.lag[st.chan])))
              * coef(st.lag_tc[st.chan])) >>> ppc_pkg::COEF_FRAC));
    cur_fn = (st.phase == S_SLOT_A) ? st.cfg[st.chan][ppc_pkg::CFG_SA +: 3]
                                    : st.cfg[st.chan][ppc_pkg::CFG_SB +: 3];
    case (cur_fn)
      ppc_pkg::FN_LINEAR: fn_res = lin_res;
      ppc_pkg::FN_CURVE:  fn_res = curve_res;
      ppc_pkg::FN_ROOT:   fn_res = root_res;
      ppc_pkg::FN_LAG:    fn_res = lag_res;
      default:            fn_res = st.work;
    endcase
    stype = st.cfg[st.chan][ppc_pkg::CFG_ST +: 2];
    rtd_hi = st.cfg[st.chan][ppc_pkg::CFG_RNG] ? ppc_pkg::RTD_HI_HI : ppc_pkg::RTD_HI_LO;
    cond_val = st.raw[st.chan];
    if (stype == ppc_pkg::ST_TC)
      cond_val = sat16(int'($signed(st.raw[st.chan])) + int'($signed(
                 st.cfg[st.chan][ppc_pkg::CFG_CJX] ? st.cj_ref : cj_internal)));
    else if (stype == ppc_pkg::ST_TDIFF)
      cond_val = sat16(int'($signed(st.raw[st.chan])) - int'($signed(st.lead_off)));
    fault_cond = st.raw_fault[st.chan];
    if (stype == ppc_pkg::ST_RTD)
    begin
      if ($signed(st.raw[st.chan]) <= $signed(ppc_pkg::RTD_BREAK))
        fault_cond = 1'b1;
      if ($signed(st.raw[st.chan]) > $signed(rtd_hi))
        fault_cond = 1'b1;
    end
    case (st.cfg[st.chan][ppc_pkg::CFG_FA +: 2])
      ppc_pkg::FA_DOWN:  subst = ppc_pkg::DOWNSCALE;
      ppc_pkg::FA_FIXED: subst = st.fixed_val[st.chan];
      default:           subst = ppc_pkg::UPSCALE;
    endcase
    filt_res = sat16(int'($signed(st.filt[st.chan])) + (((int'($signed(cond_val))
               - int'($signed(st.filt[st.chan]))) * coef(st.in_tc[st.chan]))
               >>> ppc_pkg::COEF_FRAC));
  end

  // ****************************************
  // Next state
  // ****************************************
  logic [4:0]  grp;
  logic [2:0]  idx;
  logic [15:0] clamp_tc;

  always_comb
  begin
    next_st = st;
    next_st.out_valid = 1'b0;
    grp = reg_addr[7:3];
    idx = reg_addr[2:0];
    clamp_tc = reg_wdata;
    if ($signed(reg_wdata) < $signed(ppc_pkg::TC_MIN))
      clamp_tc = ppc_pkg::TC_MIN;
    else if ($signed(reg_wdata) > $signed(ppc_pkg::TC_MAX))
      clamp_tc = ppc_pkg::TC_MAX;
    if (sample_valid && sample_chan < 3'(ppc_pkg::CH_N))
    begin
      next_st.raw[sample_chan]       = sample_value;
      next_st.raw_fault[sample_chan] = sample_fault;
    end
    // Register writes
    if (reg_wr)
    begin
      if (grp == ppc_pkg::G_CFG && idx < 3'(ppc_pkg::CH_N))
      begin
        if (fn_ok(idx, reg_wdata[ppc_pkg::CFG_SA +: 3]) && fn_ok(idx, reg_wdata[ppc_pkg::CFG_SB +: 3])
            && (reg_wdata[ppc_pkg::CFG_SA +: 3] != reg_wdata[ppc_pkg::CFG_SB +: 3]
            || reg_wdata[ppc_pkg::CFG_SA +: 3] == ppc_pkg::FN_NONE))
        begin
          next_st.cfg[idx] = reg_wdata[ppc_pkg::CFG_W-1:0];
          next_st.refused  = 1'b0;
        end
        else
          next_st.refused = 1'b1;
      end
      else if (grp == ppc_pkg::G_LGAIN && idx < 3'(ppc_pkg::CH_N))
        next_st.lin_gain[idx] = reg_wdata;
      else if (grp == ppc_pkg::G_LOFF && idx < 3'(ppc_pkg::CH_N))
        next_st.lin_off[idx] = reg_wdata;
      else if (grp == ppc_pkg::G_RGAIN && idx < 3'(ppc_pkg::CH_N))
        next_st.root_gain[idx] = reg_wdata;
      else if (grp == ppc_pkg::G_LAGTC && idx < 3'(ppc_pkg::CH_N))
        next_st.lag_tc[idx] = clamp_tc;
      else if (grp == ppc_pkg::G_INTC && idx < 3'(ppc_pkg::CH_N))
        next_st.in_tc[idx] = clamp_tc;
      else if (grp == ppc_pkg::G_FIXED && idx < 3'(ppc_pkg::CH_N))
        next_st.fixed_val[idx] = reg_wdata;
      else if (reg_addr == ppc_pkg::A_CJREF)
      begin
        if ($signed(reg_wdata) > $signed(ppc_pkg::CJ_MAX))
          next_st.cj_ref = ppc_pkg::CJ_MAX;
        else if ($signed(reg_wdata) < $signed(ppc_pkg::CJ_MIN))
          next_st.cj_ref = ppc_pkg::CJ_MIN;
        else
          next_st.cj_ref = reg_wdata;
      end
      else if (reg_addr == ppc_pkg::A_ROUTE)
        next_st.route = reg_wdata[1:0];
      else if (reg_addr == ppc_pkg::A_LEADCAL)
      begin
        next_st.lead_off = st.raw[ppc_pkg::CH_MAIN];
        next_st.cal_done = 1'b1;
      end
      else if (reg_addr[7:5] == ppc_pkg::G3_CURVE)
      begin
        if (reg_addr[0])
          next_st.by[reg_addr[4]][reg_addr[3:1]] = reg_wdata;
        else
          next_st.bx[reg_addr[4]][reg_addr[3:1]] = reg_wdata;
      end
    end
    // Register reads
    if (reg_rd)
    begin
      next_st.rdata = '0;
      if (grp == ppc_pkg::G_CFG && idx < 3'(ppc_pkg::CH_N))
        next_st.rdata = 16'(st.cfg[idx]);
      else if (grp == ppc_pkg::G_RESULT && idx < 3'(ppc_pkg::CH_N))
        next_st.rdata = st.result[idx];
      else if (reg_addr == ppc_pkg::A_STATUS)
        next_st.rdata = {7'h00, st.refused, st.off, st.tick == '0,
                         st.cfg[ppc_pkg::CH_MAIN][ppc_pkg::CFG_ST +: 2] == ppc_pkg::ST_TDIFF
                         && !st.cal_done, st.fault_now};
    end
    // Scan sequencer
    if (st.tick == 32'(SCAN_CYCLES - 1))
      next_st.tick = '0;
    else
      next_st.tick = st.tick + 32'h1;
    case (st.phase)
      S_IDLE:
      begin
        if (st.tick == 32'(SCAN_CYCLES - 1))
        begin
          next_st.chan  = '0;
          next_st.phase = S_COND;
        end
      end
      S_COND:
      begin
        next_st.fault_now[st.chan] = fault_cond;
        if (fault_cond)
          next_st.work = subst;
        else
        begin
          next_st.work = filt_res;
          next_st.filt[st.chan] = filt_res;
        end
        next_st.phase = S_SLOT_A;
      end
      S_SLOT_A, S_SLOT_B:
      begin
        next_st.work = fn_res;
        if (cur_fn == ppc_pkg::FN_LAG)
          next_st.lag[st.chan] = lag_res;
        next_st.phase = (st.phase == S_SLOT_A) ? S_SLOT_B : S_EMIT;
      end
      S_EMIT:
      begin
        next_st.result[st.chan] = st.work;
        next_st.out_valid = 1'b1;
        next_st.out_chan  = st.chan;
        next_st.out_value = st.work;
        if ((st.route == 2'h1 && st.chan == ppc_pkg::CH_AUX3)
            || (st.route == 2'h2 && st.chan == ppc_pkg::CH_AUX4)
            || (st.route[1] == st.route[0] && st.chan == ppc_pkg::CH_MAIN))
          next_st.pv = st.work;
        if (st.chan == ppc_pkg::CH_SETP)
          next_st.sp = st.work;
        if (st.chan == ppc_pkg::CH_POS)
          next_st.pos = st.work;
        if (st.chan == 3'(ppc_pkg::CH_N - 1))
        begin
          next_st.phase = S_IDLE;
          if (st.off_cnt != 8'h00)
          begin
            next_st.off_cnt = st.off_cnt - 8'h01;
            next_st.off     = st.off_cnt != 8'h01;
          end
          if (|st.fault_now)
          begin
            next_st.fault_seen = 1'b1;
            next_st.settle_cnt = '0;
          end
          else if (st.fault_seen)
          begin
            if (st.settle_cnt == 8'(ppc_pkg::SETTLE_SCANS - 1))
            begin
              next_st.fault_seen = 1'b0;
              next_st.off_cnt    = 8'(ppc_pkg::OFF_SCANS);
              next_st.off        = 1'b1;
              next_st.filt       = st.raw;
              next_st.lag        = st.raw;
            end
            else
              next_st.settle_cnt = st.settle_cnt + 8'h01;
          end
        end
        else
        begin
          next_st.chan  = st.chan + 3'h1;
          next_st.phase = S_COND;
        end
      end
      default: next_st.phase = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata         = st.rdata;
  assign out_valid         = st.out_valid;
  assign out_chan          = st.out_chan;
  assign out_value         = st.out_value;
  assign process_value     = st.pv;
  assign ext_setpoint      = st.sp;
  assign position_feedback = st.pos;
  assign outputs_off       = st.off;
  assign sensor_fault      = st.fault_now;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_SLOT_UNIQUE: assert property (
    st.cfg[st.chan][ppc_pkg::CFG_SA +: 3] != st.cfg[st.chan][ppc_pkg::CFG_SB +: 3]
    || st.cfg[st.chan][ppc_pkg::CFG_SA +: 3] == ppc_pkg::FN_NONE)
    else $error("Function in both slots");
  AST_LINEAR_MAP: assert property (
    (st.phase inside {S_SLOT_A, S_SLOT_B}) && cur_fn == ppc_pkg::FN_LINEAR
    |=> st.work == $past(lin_res))
    else $error("Linear map result wrong");
  AST_ROOT_NEG: assert property (
    (st.phase inside {S_SLOT_A, S_SLOT_B}) && cur_fn == ppc_pkg::FN_ROOT && st.work[15]
    |=> st.work == 16'h0000)
    else $error("Negative root not zero");
  AST_EMPTY_PASS: assert property (
    (st.phase inside {S_SLOT_A, S_SLOT_B}) && cur_fn == ppc_pkg::FN_NONE
    |=> $stable(st.work))
    else $error("Empty slot changed value");
  AST_SLOT_ORDER: assert property (
    st.phase == S_COND |=> st.phase == S_SLOT_A ##1 st.phase == S_SLOT_B ##1 st.phase == S_EMIT)
    else $error("Slot order broken");
  AST_FIXED_SUBST: assert property (
    st.phase == S_COND && fault_cond && st.cfg[st.chan][ppc_pkg::CFG_FA +: 2] == ppc_pkg::FA_FIXED
    |=> st.work == $past(st.fixed_val[st.chan]))
    else $error("Fixed value not substituted");
  AST_RTD_BREAK: assert property (
    st.phase == S_COND && stype == ppc_pkg::ST_RTD
    && $signed(st.raw[st.chan]) <= $signed(ppc_pkg::RTD_BREAK)
    |=> sensor_fault[$past(st.chan)])
    else $error("Break not declared");
  AST_SCAN_TICK: assert property (
    st.phase == S_IDLE && st.tick == 32'(SCAN_CYCLES - 1) |=> st.phase == S_COND && st.chan == 3'h0)
    else $error("Scan did not start");
  AST_TC_RANGE: assert property (
    $signed(st.in_tc[st.chan]) >= $signed(ppc_pkg::TC_MIN)
    && $signed(st.in_tc[st.chan]) <= $signed(ppc_pkg::TC_MAX))
    else $error("Filter time out of range");
  AST_CJ_RANGE: assert property (
    $signed(st.cj_ref) >= $signed(ppc_pkg::CJ_MIN) && $signed(st.cj_ref) <= $signed(ppc_pkg::CJ_MAX))
    else $error("Reference temperature out of range");
endmodule

// [design/ppc_pkg.sv]
package ppc_pkg;
  // ****************************************
  // Sizes and channel numbers
  // ****************************************
  localparam int CH_N = 5;
  localparam int BP_N = 8;
  localparam int CV_N = 2;
  localparam logic [2:0] CH_MAIN = 3'h0;
  localparam logic [2:0] CH_AUX3 = 3'h1;
  localparam logic [2:0] CH_AUX4 = 3'h2;
  localparam logic [2:0] CH_SETP = 3'h3;
  localparam logic [2:0] CH_POS  = 3'h4;
  // ****************************************
  // Function codes, fault actions, sensor types
  // ****************************************
  localparam logic [2:0] FN_NONE   = 3'h0;
  localparam logic [2:0] FN_LINEAR = 3'h1;
  localparam logic [2:0] FN_CURVE  = 3'h2;
  localparam logic [2:0] FN_ROOT   = 3'h3;
  localparam logic [2:0] FN_LAG    = 3'h4;
  localparam logic [1:0] FA_UP     = 2'h0;
  localparam logic [1:0] FA_DOWN   = 2'h1;
  localparam logic [1:0] FA_FIXED  = 2'h2;
  localparam logic [1:0] ST_SIGNAL = 2'h0;
  localparam logic [1:0] ST_TC     = 2'h1;
  localparam logic [1:0] ST_RTD    = 2'h2;
  localparam logic [1:0] ST_TDIFF  = 2'h3;
  // ****************************************
  // Channel configuration word fields
  // ****************************************
  localparam int CFG_W   = 12;
  localparam int CFG_SA  = 0;
  localparam int CFG_SB  = 3;
  localparam int CFG_FA  = 6;
  localparam int CFG_ST  = 8;
  localparam int CFG_CJX = 10;
  localparam int CFG_RNG = 11;
  // ****************************************
  // Register word addresses
  // ****************************************
  localparam logic [4:0] G_CFG    = 5'h00;
  localparam logic [4:0] G_LGAIN  = 5'h01;
  localparam logic [4:0] G_LOFF   = 5'h02;
  localparam logic [4:0] G_RGAIN  = 5'h03;
  localparam logic [4:0] G_LAGTC  = 5'h04;
  localparam logic [4:0] G_INTC   = 5'h05;
  localparam logic [4:0] G_FIXED  = 5'h06;
  localparam logic [4:0] G_RESULT = 5'h0C;
  localparam logic [7:0] A_CJREF   = 8'h38;
  localparam logic [7:0] A_ROUTE   = 8'h39;
  localparam logic [7:0] A_LEADCAL = 8'h3A;
  localparam logic [7:0] A_STATUS  = 8'h3B;
  localparam logic [2:0] G3_CURVE  = 3'h2;
  // ****************************************
  // Values in tenths of a unit, gains in 1/256 units
  // ****************************************
  localparam logic [15:0] X_DISABLED = 16'h8000;
  localparam logic [15:0] UPSCALE    = 16'h7FFF;
  localparam logic [15:0] DOWNSCALE  = 16'h8001;
  localparam logic [15:0] RTD_BREAK  = 16'hFAEC;
  localparam logic [15:0] RTD_LOW    = 16'hFC19;
  localparam logic [15:0] RTD_HI_LO  = 16'h09C4;
  localparam logic [15:0] RTD_HI_HI  = 16'h2134;
  localparam logic [15:0] CJ_MIN     = 16'h0000;
  localparam logic [15:0] CJ_MAX     = 16'h03E8;
  localparam logic [15:0] TC_MIN     = 16'h0005;
  localparam logic [15:0] TC_MAX     = 16'h270F;
  localparam logic [15:0] GAIN_ONE   = 16'h0100;
  localparam int GAIN_FRAC = 8;
  localparam int COEF_FRAC = 16;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ    = 25000;
  localparam int SCAN_MS    = 100;
  localparam int SETTLE_MS  = 10000;
  localparam int OFF_MS     = 3000;
  localparam int TC_UNIT_MS = 100;
  localparam int SCAN_CYCLES  = SCAN_MS * CLK_KHZ;
  localparam int SETTLE_SCANS = SETTLE_MS / SCAN_MS;
  localparam int OFF_SCANS    = OFF_MS / SCAN_MS;
  localparam int SAMPLE_UNITS = SCAN_MS / TC_UNIT_MS;
endpackage
